// *** rucb_defines.vh ***
// offsets, reset values, field positions and timing for the upper config bank
`ifndef RUCB_DEFINES_VH
`define RUCB_DEFINES_VH
`define RUCB_ADDR_FIRST      5'h0e
`define RUCB_ADDR_HP3        5'h0e
`define RUCB_ADDR_HP4        5'h0f
`define RUCB_ADDR_BLKEN      5'h10
`define RUCB_ADDR_FRAC_LO    5'h11
`define RUCB_ADDR_FRAC_HI    5'h12
`define RUCB_ADDR_INT        5'h13
`define RUCB_ADDR_SYN1       5'h14
`define RUCB_ADDR_SYN2       5'h15
`define RUCB_ADDR_VAS        5'h16
`define RUCB_ADDR_LOMISC     5'h17
`define RUCB_ADDR_XTAL       5'h18
`define RUCB_ADDR_VCO        5'h19
`define RUCB_ADDR_LO_GENERATOR      5'h1a
`define RUCB_ADDR_PADRV      5'h1b
`define RUCB_ADDR_PA_BIAS_DAC      5'h1c
`define RUCB_ADDR_TXGAIN     5'h1d
`define RUCB_ADDR_TXIQ       5'h1e
`define RUCB_ADDR_TXDC       5'h1f
`define RUCB_RST_HP3         10'h3c5
`define RUCB_RST_HP4         10'h201
`define RUCB_RST_BLKEN       10'h01c
`define RUCB_RST_FRAC_LO     10'h155
`define RUCB_RST_FRAC_HI     10'h155
`define RUCB_RST_INT         10'h153
`define RUCB_RST_SYN1        10'h249
`define RUCB_RST_SYN2        10'h02d
`define RUCB_RST_VAS         10'h1a9
`define RUCB_RST_LOMISC      10'h24f
`define RUCB_RST_XTAL        10'h180
`define RUCB_RST_VCO         10'h000
`define RUCB_RST_LO_GENERATOR       10'h3c0
`define RUCB_RST_PADRV       10'h200
`define RUCB_RST_PA_BIAS_DAC       10'h0c0
`define RUCB_RST_TXGAIN      10'h03f
`define RUCB_RST_TXIQ        10'h380
`define RUCB_RST_TXDC        10'h340
`define RUCB_HP3_GATE_BIT    9
`define RUCB_HP3_RETRIG_BIT  8
`define RUCB_HP4_SEQUENCER_MODE_TWO_BIT   9
`define RUCB_HP4_BYPASS_BIT  6
`define RUCB_HP4_XTAL40_BIT  0
`define RUCB_BLK_TXDAC_BIT   7
`define RUCB_BLK_DAC_BIT     6
`define RUCB_BLK_CAL_BIT     1
`define RUCB_BLK_CHIP_BIT    0
`define RUCB_VAS_TRIG_BIT    7
`define RUCB_VAS_RELOCK_BIT  1
`define RUCB_VAS_AUTO_BIT    0
`define RUCB_PADRV_DC_BIT    8
`define RUCB_PADRV_GAIN_BIT  7
`define RUCB_PADRV_PHASE_BIT 6
`define RUCB_CLK_PERIOD_NS   5
`define RUCB_SEQ_TICK_NS     200
`define RUCB_HOLD_STEP_NS    3200
`define RUCB_EDGE_STEP_NS    200
`define RUCB_PA_BIAS_DAC_STEP_NS   500
`define RUCB_XTAL_PER_TICK40 4'd8
`define RUCB_XTAL_PER_TICK20 4'd4
`define RUCB_VAS_FACTOR      15'd7
`define RUCB_SUBBAND_RELOCK  5'd15
`define RUCB_CORNER_600K     3'd4
`define RUCB_FRAME_BITS      16
`define RUCB_HDR_BITS        6
`endif

// *** rucb_timer.v ***
// countdown timer: loads a count on start, finishes after that many ticks
`timescale 1ns/1ps
`default_nettype none
module rucb_timer #(
    parameter W = 14
) (
    // clock and control
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    // request
    input  wire         start,
    input  wire         tick,
    input  wire [W-1:0] load,
    // status
    output reg          busy,
    output reg          done
);
    reg [W-1:0] cnt;

    // a zero load finishes on the next edge, so a 0 us setting still passes
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt  <= {W{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (start)
            begin
                cnt  <= load;
                busy <= (load != {W{1'b0}});
                done <= (load == {W{1'b0}});
            end
            else if (busy && tick)
            begin
                if (cnt == {{(W-1){1'b0}}, 1'b1})
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// *** rucb_serial_port.v ***
// four-wire serial port: r/w bit, 5-bit address, 10-bit data, msb first
`timescale 1ns/1ps
`default_nettype none
`include "rucb_defines.vh"
module rucb_serial_port (
    // clock and control
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ce,
    // pins
    input  wire       csn,
    input  wire       sclk,
    input  wire       din,
    output reg        dout,
    output reg        dout_oe,
    // register side
    output reg  [4:0] addr,
    output reg  [9:0] wdata,
    output reg        wr,
    input  wire [9:0] rdata
);
    reg        sclk_q;
    reg        rw;
    reg [3:0]  cnt;
    reg [14:0] sh;
    wire       rise = sclk & ~sclk_q;
    wire       fall = ~sclk & sclk_q;
    wire [3:0] bit_idx = 4'd15 - cnt;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q  <= 1'b0;
            rw      <= 1'b0;
            cnt     <= 4'h0;
            sh      <= 15'h0;
            dout    <= 1'b0;
            dout_oe <= 1'b0;
            addr    <= 5'h0;
            wdata   <= 10'h0;
            wr      <= 1'b0;
        end
        else if (ce)
        begin
            sclk_q <= sclk;
            wr     <= 1'b0;
            if (csn)
            begin
                cnt     <= 4'h0;
                dout_oe <= 1'b0;
            end
            else
            begin
                dout_oe <= 1'b1;
                if (rise)
                begin
                    sh  <= {sh[13:0], din};
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'd5)
                    begin
                        rw   <= sh[4];
                        addr <= {sh[3:0], din};
                    end
                    if (cnt == 4'd15)
                    begin
                        wdata <= {sh[8:0], din};
                        wr    <= ~rw;
                    end
                end
                // readback leaves on the falling edge, one data bit per clock
                if (fall && rw && cnt >= 4'd6)
                    dout <= rdata[bit_idx];
            end
        end
    end
endmodule
`default_nettype wire

// *** rucb_top.v ***
// register bank 14 to 31 and the logic its fields steer
`timescale 1ns/1ps
`default_nettype none
`include "rucb_defines.vh"
module rucb_top (
    // clock, reset, enable
    input  wire        REF_CLK,
    input  wire        RESETN,
    input  wire        CLK_EN,
    // serial port
    input  wire        SPI_CSN,
    input  wire        SPI_SCLK,
    input  wire        SPI_DIN,
    output wire        SPI_DOUT,
    output wire        SPI_DOUT_OE,
    // mode pins and status inputs
    input  wire        CHIP_ENABLE_PIN,
    input  wire        RECEIVE_ENABLE_PIN,
    input  wire        TRANSMIT_ENABLE_PIN,
    input  wire        XTAL_TICK,
    input  wire        VCO_OUT_OF_LOCK,
    input  wire        PLL_LOCK_INDICATION,
    input  wire        GAIN_BIT7,
    input  wire        GAIN_BIT6,
    input  wire        HIGHPASS_HOLD_PIN,
    // trim and pin sources for the transmit muxes
    input  wire [5:0]  TX_GAIN_PINS,
    input  wire [5:0]  TX_PHASE_TRIM,
    input  wire [5:0]  TX_OFFSET_FUSE_I,
    input  wire [5:0]  TX_OFFSET_FUSE_Q,
    // power and mode controls
    output reg         CHIP_ON,
    output reg         XTAL_CORE_ON,
    output reg         CAL_MODE,
    output reg         CAL_RX,
    output reg         CAL_TX,
    output reg         PA_DRIVER_ON,
    output reg         PA_BIAS_DAC_ON,
    // highpass sequencer
    output reg  [2:0]  HP_CORNER,
    output reg         CORNER_CTRL_A,
    output reg         CORNER_CTRL_D,
    // synthesizer
    output reg  [19:0] SYNTH_FRAC,
    output reg  [7:0]  SYNTH_INT,
    output reg  [1:0]  LO_BAND,
    output reg  [3:0]  REF_DIV_RATIO,
    output reg         VAS_BUSY,
    output reg  [4:0]  VCO_SUBBAND,
    // transmit muxes
    output reg  [5:0]  TX_GAIN,
    output reg  [5:0]  TX_PHASE,
    output reg  [5:0]  TX_OFFSET_I,
    output reg  [5:0]  TX_OFFSET_Q
);
    localparam ST_FINAL  = 2'd0;
    localparam ST_HOLD1K = 2'd1;
    localparam ST_M2     = 2'd2;
    localparam [13:0] HOLD_TICKS = `RUCB_HOLD_STEP_NS / `RUCB_SEQ_TICK_NS;
    localparam [13:0] EDGE_TICKS = `RUCB_EDGE_STEP_NS / `RUCB_SEQ_TICK_NS;
    localparam [13:0] DAC_STEP   = `RUCB_PA_BIAS_DAC_STEP_NS / `RUCB_CLK_PERIOD_NS;

    reg  [9:0]  regs [14:31];
    wire [4:0]  sp_addr;
    wire [9:0]  sp_wdata;
    wire        sp_wr;
    wire [9:0]  sp_rdata;
    integer     i;

    function [9:0] rst_val;
        input [4:0] a;
        begin
            case (a)
                `RUCB_ADDR_HP3:     rst_val = `RUCB_RST_HP3;
                `RUCB_ADDR_HP4:     rst_val = `RUCB_RST_HP4;
                `RUCB_ADDR_BLKEN:   rst_val = `RUCB_RST_BLKEN;
                `RUCB_ADDR_FRAC_LO: rst_val = `RUCB_RST_FRAC_LO;
                `RUCB_ADDR_FRAC_HI: rst_val = `RUCB_RST_FRAC_HI;
                `RUCB_ADDR_INT:     rst_val = `RUCB_RST_INT;
                `RUCB_ADDR_SYN1:    rst_val = `RUCB_RST_SYN1;
                `RUCB_ADDR_SYN2:    rst_val = `RUCB_RST_SYN2;
                `RUCB_ADDR_VAS:     rst_val = `RUCB_RST_VAS;
                `RUCB_ADDR_LOMISC:  rst_val = `RUCB_RST_LOMISC;
                `RUCB_ADDR_XTAL:    rst_val = `RUCB_RST_XTAL;
                `RUCB_ADDR_VCO:     rst_val = `RUCB_RST_VCO;
                `RUCB_ADDR_LO_GENERATOR:   rst_val = `RUCB_RST_LO_GENERATOR;
                `RUCB_ADDR_PADRV:   rst_val = `RUCB_RST_PADRV;
                `RUCB_ADDR_PA_BIAS_DAC:   rst_val = `RUCB_RST_PA_BIAS_DAC;
                `RUCB_ADDR_TXGAIN:  rst_val = `RUCB_RST_TXGAIN;
                `RUCB_ADDR_TXIQ:    rst_val = `RUCB_RST_TXIQ;
                `RUCB_ADDR_TXDC:    rst_val = `RUCB_RST_TXDC;
                default:            rst_val = 10'h000;
            endcase
        end
    endfunction

    rucb_serial_port u_port (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .ce      (CLK_EN),
        .csn     (SPI_CSN),
        .sclk    (SPI_SCLK),
        .din     (SPI_DIN),
        .dout    (SPI_DOUT),
        .dout_oe (SPI_DOUT_OE),
        .addr    (sp_addr),
        .wdata   (sp_wdata),
        .wr      (sp_wr),
        .rdata   (sp_rdata)
    );

    // lower addresses belong elsewhere: writes dropped, reads give zero
    assign sp_rdata = (sp_addr >= `RUCB_ADDR_FIRST) ? regs[sp_addr] : 10'h000;

    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            for (i = 14; i < 32; i = i + 1)
                regs[i] <= rst_val(i[4:0]);
        end
        else if (CLK_EN && sp_wr && sp_addr >= `RUCB_ADDR_FIRST)
            regs[sp_addr] <= sp_wdata;
    end

    wire [9:0] hp3   = regs[`RUCB_ADDR_HP3];
    wire [9:0] hp4   = regs[`RUCB_ADDR_HP4];
    wire [9:0] blken = regs[`RUCB_ADDR_BLKEN];
    wire [9:0] vco_auto_select   = regs[`RUCB_ADDR_VAS];
    wire [9:0] padrv = regs[`RUCB_ADDR_PADRV];
    wire [9:0] pa_bias_dac = regs[`RUCB_ADDR_PA_BIAS_DAC];

    // power and lock gating
    wire chip_on   = blken[`RUCB_BLK_CHIP_BIT] & CHIP_ENABLE_PIN;
    wire lock_bad  = VCO_OUT_OF_LOCK | ~PLL_LOCK_INDICATION;
    wire pa_gate   = hp3[`RUCB_HP3_GATE_BIT] & lock_bad;
    wire dac_tx    = blken[`RUCB_BLK_TXDAC_BIT] & TRANSMIT_ENABLE_PIN;
    wire dac_req   = chip_on & ~pa_gate & (blken[`RUCB_BLK_DAC_BIT] | dac_tx);
    reg  gate_q;
    reg  dac_req_q;

    // turn-on delay code 0 and 1 both mean no delay, then half-microsecond steps
    wire [3:0]  dac_code = pa_bias_dac[9:6];
    wire [13:0] dac_load = (dac_code > 4'd1) ?
                           ({10'h0, dac_code - 4'd1} * DAC_STEP) : 14'h0;
    wire        dac_done;
    wire        dac_start = dac_req & ~dac_req_q;

    rucb_timer #(.W(14)) u_dac_delay (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .ce    (CLK_EN),
        .start (dac_start),
        .tick  (1'b1),
        .load  (dac_load),
        .busy  (),
        .done  (dac_done)
    );

    // sequencer tick: one per 0.2 us whichever crystal is fitted
    reg  [3:0] pre_cnt;
    wire [3:0] pre_end = hp4[`RUCB_HP4_XTAL40_BIT] ?
                         `RUCB_XTAL_PER_TICK40 : `RUCB_XTAL_PER_TICK20;
    wire       seq_tick = XTAL_TICK && (pre_cnt == pre_end - 4'd1);

    // highpass sequencer
    reg  [1:0] seq_state;
    reg        hold_q;
    reg        g7_q;
    reg        g6_q;
    wire       mode_two  = hp4[`RUCB_HP4_SEQUENCER_MODE_TWO_BIT];
    wire       hold_on   = mode_two & HIGHPASS_HOLD_PIN;
    wire       hold_fall = mode_two & hold_q & ~HIGHPASS_HOLD_PIN;
    wire       bypass    = hp4[`RUCB_HP4_BYPASS_BIT];
    wire       gain_chg  = (GAIN_BIT7 ^ g7_q) | (GAIN_BIT6 ^ g6_q);
    wire       gain_trig = hp3[`RUCB_HP3_RETRIG_BIT] & gain_chg;
    wire       seq_start = ~hold_on & ((hold_fall & ~bypass) | gain_trig);
    wire [13:0] hold_load = {12'h0, hp3[1:0]} * HOLD_TICKS;
    wire       hold_done;

    rucb_timer #(.W(14)) u_hold (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .ce    (CLK_EN),
        .start (seq_start),
        .tick  (seq_tick),
        .load  (hold_load),
        .busy  (),
        .done  (hold_done)
    );

    reg [1:0] next_state;
    always @*
    begin
        next_state = seq_state;
        if (hold_on)
            next_state = ST_M2;
        else if (hold_fall && bypass)
            next_state = ST_FINAL;
        else if (seq_start)
            next_state = ST_HOLD1K;
        else
        begin
            case (seq_state)
                ST_HOLD1K: if (hold_done) next_state = ST_FINAL;
                ST_M2:     next_state = ST_FINAL;
                ST_FINAL:  next_state = ST_FINAL;
                default:   next_state = ST_FINAL;
            endcase
        end
    end

    // corner code: 0=100Hz 1=1kHz 2=30kHz 3=100kHz 4=600kHz
    reg [2:0] next_corner;
    always @*
    begin
        case (next_state)
            ST_M2:     next_corner = {1'b0, hp3[7:6]} + 3'd1;
            ST_HOLD1K: next_corner = 3'd1;
            default:   next_corner = {1'b0, hp3[5:4]};
        endcase
    end

    // lower corners: control rising edges wait, falling edges do not
    reg        low_q;
    wire       low_req    = (next_corner != `RUCB_CORNER_600K);
    wire       edge_start = low_req & ~low_q;
    wire [13:0] edge_load = {12'h0, hp3[3:2]} * EDGE_TICKS;
    wire       edge_done;

    rucb_timer #(.W(14)) u_edge (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .ce    (CLK_EN),
        .start (edge_start),
        .tick  (seq_tick),
        .load  (edge_load),
        .busy  (),
        .done  (edge_done)
    );

    // vco auto-select
    wire [2:0]  vdiv_code = vco_auto_select[4:2];
    wire [14:0] autoselect_clock_divide   = (vdiv_code == 3'd7) ? 15'd2 : {12'h0, vdiv_code} + 15'd8;
    wire [14:0] autoselect_delay_ratio   = 15'd16 << vco_auto_select[6:5];
    wire [14:0] vas_load  = autoselect_clock_divide * autoselect_delay_ratio * `RUCB_VAS_FACTOR;
    wire        frac_wr   = sp_wr && (sp_addr == `RUCB_ADDR_FRAC_LO);
    wire        relock    = pa_gate & ~gate_q;
    wire        vas_go    = (frac_wr & vco_auto_select[`RUCB_VAS_TRIG_BIT]) | relock;
    wire        vas_busy;
    reg  [4:0]  vas_sub;

    rucb_timer #(.W(15)) u_vas (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .ce    (CLK_EN),
        .start (vas_go),
        .tick  (XTAL_TICK),
        .load  (vas_load),
        .busy  (vas_busy),
        .done  ()
    );

    // reference divider decode
    reg [3:0] ref_div;
    always @*
    begin
        case (regs[`RUCB_ADDR_SYN1][2:1])
            2'b00:   ref_div = 4'd1;
            2'b01:   ref_div = 4'd2;
            2'b10:   ref_div = 4'd4;
            default: ref_div = 4'd8;
        endcase
    end

    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            gate_q    <= 1'b0;
            dac_req_q <= 1'b0;
            pre_cnt   <= 4'h0;
            seq_state <= ST_FINAL;
            hold_q    <= 1'b0;
            g7_q      <= 1'b0;
            g6_q      <= 1'b0;
            low_q     <= 1'b0;
            vas_sub   <= `RUCB_SUBBAND_RELOCK;
        end
        else if (CLK_EN)
        begin
            gate_q    <= pa_gate;
            dac_req_q <= dac_req;
            if (XTAL_TICK)
                pre_cnt <= seq_tick ? 4'h0 : pre_cnt + 4'h1;
            seq_state <= next_state;
            hold_q    <= HIGHPASS_HOLD_PIN;
            g7_q      <= GAIN_BIT7;
            g6_q      <= GAIN_BIT6;
            low_q     <= low_req;
            // search start point; the found band itself is analog and not kept here
            if (vas_go && !vco_auto_select[`RUCB_VAS_RELOCK_BIT])
                vas_sub <= `RUCB_SUBBAND_RELOCK;
        end
    end

    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            CHIP_ON        <= 1'b0;
            XTAL_CORE_ON   <= 1'b0;
            CAL_MODE       <= 1'b0;
            CAL_RX         <= 1'b0;
            CAL_TX         <= 1'b0;
            PA_DRIVER_ON   <= 1'b0;
            PA_BIAS_DAC_ON <= 1'b0;
            HP_CORNER      <= 3'd0;
            CORNER_CTRL_A  <= 1'b0;
            CORNER_CTRL_D  <= 1'b0;
            SYNTH_FRAC     <= 20'h0;
            SYNTH_INT      <= 8'h0;
            LO_BAND        <= 2'b0;
            REF_DIV_RATIO  <= 4'd1;
            VAS_BUSY       <= 1'b0;
            VCO_SUBBAND    <= 5'h0;
            TX_GAIN        <= 6'h0;
            TX_PHASE       <= 6'h0;
            TX_OFFSET_I    <= 6'h0;
            TX_OFFSET_Q    <= 6'h0;
        end
        else if (CLK_EN)
        begin
            CHIP_ON      <= chip_on;
            // oscillator sits outside the chip gating
            XTAL_CORE_ON <= regs[`RUCB_ADDR_XTAL][9];
            CAL_MODE     <= blken[`RUCB_BLK_CAL_BIT];
            CAL_RX       <= blken[`RUCB_BLK_CAL_BIT] & RECEIVE_ENABLE_PIN;
            CAL_TX       <= blken[`RUCB_BLK_CAL_BIT] & TRANSMIT_ENABLE_PIN;
            PA_DRIVER_ON <= chip_on & ~pa_gate;
            // drops at once when the request goes, rises only after the delay
            PA_BIAS_DAC_ON <= dac_req & (PA_BIAS_DAC_ON | dac_done);
            HP_CORNER     <= next_corner;
            CORNER_CTRL_A <= low_req & (CORNER_CTRL_A | edge_done);
            CORNER_CTRL_D <= low_req & (CORNER_CTRL_D | edge_done);
            SYNTH_FRAC <= {regs[`RUCB_ADDR_FRAC_HI], regs[`RUCB_ADDR_FRAC_LO]};
            SYNTH_INT  <= regs[`RUCB_ADDR_INT][7:0];
            LO_BAND    <= regs[`RUCB_ADDR_INT][9:8];
            REF_DIV_RATIO <= ref_div;
            VAS_BUSY   <= vas_busy;
            VCO_SUBBAND <= vco_auto_select[`RUCB_VAS_AUTO_BIT] ?
                           vas_sub : regs[`RUCB_ADDR_LOMISC][4:0];
            TX_GAIN  <= padrv[`RUCB_PADRV_GAIN_BIT] ?
                        regs[`RUCB_ADDR_TXGAIN][5:0] : TX_GAIN_PINS;
            TX_PHASE <= padrv[`RUCB_PADRV_PHASE_BIT] ?
                        padrv[5:0] : TX_PHASE_TRIM;
            TX_OFFSET_I <= padrv[`RUCB_PADRV_DC_BIT] ?
                           regs[`RUCB_ADDR_TXIQ][5:0] : TX_OFFSET_FUSE_I;
            TX_OFFSET_Q <= padrv[`RUCB_PADRV_DC_BIT] ?
                           regs[`RUCB_ADDR_TXDC][5:0] : TX_OFFSET_FUSE_Q;
        end
    end
endmodule
`default_nettype wire

// *** rucb_props.sv ***
// port checks for the upper config bank
`timescale 1ns/1ps
`default_nettype none
module rucb_props (
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RESETN,
    // watched ports
    input wire logic        SPI_CSN,
    input wire logic        SPI_DOUT_OE,
    input wire logic        CHIP_ENABLE_PIN,
    input wire logic        RECEIVE_ENABLE_PIN,
    input wire logic        CHIP_ON,
    input wire logic        CAL_RX,
    input wire logic        PA_DRIVER_ON,
    input wire logic        PA_BIAS_DAC_ON,
    input wire logic [2:0]  HP_CORNER,
    input wire logic        CORNER_CTRL_A,
    input wire logic        CORNER_CTRL_D,
    input wire logic [19:0] SYNTH_FRAC,
    input wire logic [3:0]  REF_DIV_RATIO
);
    // cycles since chip select went high, saturating
    logic [3:0] idle;
    always @(posedge REF_CLK or negedge RESETN)
        if (!RESETN)
            idle <= 4'd0;
        else
            idle <= SPI_CSN ? idle + {3'd0, idle != 4'hf} : 4'd0;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    sequence csn_low2; !SPI_CSN [*2]; endsequence
    sequence csn_high2; SPI_CSN [*2]; endsequence
    sequence chip_off3; !CHIP_ON [*3]; endsequence
    a_chip_pin_gate: assert property (CHIP_ON |-> $past(CHIP_ENABLE_PIN))
        else $error("chip on without pin");
    a_cal_rx_pin: assert property (CAL_RX |-> $past(RECEIVE_ENABLE_PIN))
        else $error("rx cal without pin");
    a_oe_on: assert property (csn_low2 |-> SPI_DOUT_OE)
        else $error("dout not driven");
    a_oe_off: assert property (csn_high2 |-> !SPI_DOUT_OE)
        else $error("dout driven idle");
    a_pa_off_chip: assert property (chip_off3 |-> !PA_DRIVER_ON && !PA_BIAS_DAC_ON)
        else $error("pa on while chip off");
    a_ctrl_same: assert property (CORNER_CTRL_A == CORNER_CTRL_D)
        else $error("corner controls differ");
    a_ctrl_fall: assert property (HP_CORNER == 3'd4 |=> !CORNER_CTRL_A)
        else $error("control high at 600k");
    a_ctrl_rise_late: assert property ($rose(CORNER_CTRL_A) |->
        $past(HP_CORNER) != 3'd4 && HP_CORNER != 3'd4)
        else $error("control rose early");
    a_frac_quiet: assert property ($changed(SYNTH_FRAC) |-> idle < 4'd8)
        else $error("frac changed without frame");
    a_ref_onehot: assert property ($onehot(REF_DIV_RATIO))
        else $error("bad ref divide");
endmodule
bind rucb_top rucb_props i_rucb_props (.REF_CLK, .RESETN, .SPI_CSN, .SPI_DOUT_OE,
    .CHIP_ENABLE_PIN, .RECEIVE_ENABLE_PIN, .CHIP_ON, .CAL_RX, .PA_DRIVER_ON,
    .PA_BIAS_DAC_ON, .HP_CORNER, .CORNER_CTRL_A, .CORNER_CTRL_D, .SYNTH_FRAC, .REF_DIV_RATIO);
`default_nettype wire

// *** rucb_host.sv ***
// serial-port host model
`timescale 1ns/1ps
`default_nettype none
module rucb_host (
    // clock
    input  wire logic clk,
    // serial pins
    output var  logic csn,
    output var  logic sclk,
    output var  logic din,
    input  wire logic dout
);
    initial
    begin
        csn = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // each phase held 3 cycles, the port needs one
    task xfer(input logic rd, input logic [4:0] a, input logic [9:0] d, output logic [9:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        @(posedge clk) #1 csn = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            din = f[i];
            sclk = 1'b0;
            repeat (3) @(posedge clk);
            #1 if (i < 10) q[i] = dout;
            sclk = 1'b1;
            repeat (3) @(posedge clk);
            #1;
        end
        csn = 1'b1;
        din = ~din; // released line must not look stable
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// *** rucb_top_bench.sv ***
// self-checking bench for the upper config bank
`timescale 1ns/1ps
`default_nettype none
`include "rucb_defines.vh"
module rucb_top_bench;
    logic        REF_CLK = 0, RESETN = 0, CLK_EN = 1, HIGHPASS_HOLD_PIN = 0;
    logic        CHIP_ENABLE_PIN = 0, RECEIVE_ENABLE_PIN = 0, TRANSMIT_ENABLE_PIN = 0;
    logic        VCO_OUT_OF_LOCK = 0, PLL_LOCK_INDICATION = 1, GAIN_BIT7 = 0, GAIN_BIT6 = 0;
    logic [5:0]  TX_GAIN_PINS = 0, TX_PHASE_TRIM = 0, TX_OFFSET_FUSE_I = 0, TX_OFFSET_FUSE_Q = 0;
    logic [2:0]  xc = 0;
    logic [9:0]  q, sh [14:31];
    wire         SPI_CSN, SPI_SCLK, SPI_DIN, SPI_DOUT, SPI_DOUT_OE, XTAL_TICK, CHIP_ON;
    wire         XTAL_CORE_ON, CAL_MODE, CAL_RX, CAL_TX, PA_DRIVER_ON, PA_BIAS_DAC_ON;
    wire         CORNER_CTRL_A, CORNER_CTRL_D, VAS_BUSY;
    wire [2:0]   HP_CORNER;
    wire [19:0]  SYNTH_FRAC;
    wire [7:0]   SYNTH_INT;
    wire [1:0]   LO_BAND;
    wire [3:0]   REF_DIV_RATIO;
    wire [4:0]   VCO_SUBBAND;
    wire [5:0]   TX_GAIN, TX_PHASE, TX_OFFSET_I, TX_OFFSET_Q;
    integer      mismatches = 0, n_compared = 0, i;
    localparam logic [179:0] DFLT = {`RUCB_RST_TXDC, `RUCB_RST_TXIQ, `RUCB_RST_TXGAIN,
        `RUCB_RST_PA_BIAS_DAC, `RUCB_RST_PADRV, `RUCB_RST_LO_GENERATOR, `RUCB_RST_VCO, `RUCB_RST_XTAL,
        `RUCB_RST_LOMISC, `RUCB_RST_VAS, `RUCB_RST_SYN2, `RUCB_RST_SYN1, `RUCB_RST_INT,
        `RUCB_RST_FRAC_HI, `RUCB_RST_FRAC_LO, `RUCB_RST_BLKEN, `RUCB_RST_HP4, `RUCB_RST_HP3};
    always #2.5 REF_CLK = ~REF_CLK;
    // 40 MHz crystal: one pulse every 5 cycles
    always @(posedge REF_CLK) xc <= #1 (xc == 3'd4) ? 3'd0 : xc + 3'd1;
    assign XTAL_TICK = (xc == 3'd0);
    rucb_host i_rucb_host (.clk(REF_CLK), .csn(SPI_CSN), .sclk(SPI_SCLK), .din(SPI_DIN),
        .dout(SPI_DOUT));
    rucb_top i_rucb_top (.REF_CLK, .RESETN, .CLK_EN, .SPI_CSN, .SPI_SCLK, .SPI_DIN, .SPI_DOUT,
        .SPI_DOUT_OE, .CHIP_ENABLE_PIN, .RECEIVE_ENABLE_PIN, .TRANSMIT_ENABLE_PIN, .XTAL_TICK,
        .VCO_OUT_OF_LOCK, .PLL_LOCK_INDICATION, .GAIN_BIT7, .GAIN_BIT6, .HIGHPASS_HOLD_PIN,
        .TX_GAIN_PINS, .TX_PHASE_TRIM, .TX_OFFSET_FUSE_I, .TX_OFFSET_FUSE_Q, .CHIP_ON,
        .XTAL_CORE_ON, .CAL_MODE, .CAL_RX, .CAL_TX, .PA_DRIVER_ON, .PA_BIAS_DAC_ON, .HP_CORNER,
        .CORNER_CTRL_A, .CORNER_CTRL_D, .SYNTH_FRAC, .SYNTH_INT, .LO_BAND, .REF_DIV_RATIO,
        .VAS_BUSY, .VCO_SUBBAND, .TX_GAIN, .TX_PHASE, .TX_OFFSET_I, .TX_OFFSET_Q);
    task check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task wr(input logic [4:0] a, input logic [9:0] d);
        i_rucb_host.xfer(1'b0, a, d, q);
        if (a >= 5'd14) sh[a] = d;
    endtask
    function automatic logic [5:0] pick(input logic s, input logic [5:0] r, input logic [5:0] p);
        return s ? r : p;
    endfunction
    initial
    begin
        repeat (50000) @(posedge REF_CLK);
        mismatches++;
        end_sim;
    end
    initial
    begin
        i = $urandom(56021);
        repeat (20) @(posedge REF_CLK);
        #1 RESETN = 1;
        for (i = 14; i < 32; i++)
        begin
            i_rucb_host.xfer(1'b1, i[4:0], 10'h0, q);
            check("default", q, DFLT[(i-14)*10 +: 10]);
        end
        wr(5'd3, 10'h3ff);
        i_rucb_host.xfer(1'b1, 5'd3, 10'h0, q);
        check("unmapped", q, 10'h0);
        {TX_GAIN_PINS, TX_PHASE_TRIM, TX_OFFSET_FUSE_I, TX_OFFSET_FUSE_Q} = {$urandom, $urandom};
        {VCO_OUT_OF_LOCK, PLL_LOCK_INDICATION} = $urandom;
        for (i = 14; i < 32; i++)
            wr(i[4:0], $urandom);
        for (i = 14; i < 32; i++)
        begin
            i_rucb_host.xfer(1'b1, i[4:0], 10'h0, q);
            check("readback", q, sh[i]);
        end
        check("frac", SYNTH_FRAC, {sh[18], sh[17]});
        check("int", {LO_BAND, SYNTH_INT}, sh[19]);
        check("refdiv", REF_DIV_RATIO, 4'd1 << sh[20][2:1]);
        check("gain", TX_GAIN, pick(sh[27][7], sh[29][5:0], TX_GAIN_PINS));
        check("phase", TX_PHASE, pick(sh[27][6], sh[27][5:0], TX_PHASE_TRIM));
        check("offset", TX_OFFSET_I, pick(sh[27][8], sh[30][5:0], TX_OFFSET_FUSE_I));
        check("xq", {XTAL_CORE_ON, TX_OFFSET_Q},
            {sh[24][9], pick(sh[27][8], sh[31][5:0], TX_OFFSET_FUSE_Q)});
        wr(5'h16, sh[22] & 10'h3fe);
        check("subband", VCO_SUBBAND, sh[23][4:0]);
        for (i = 0; i < 32; i++)
        begin
            {CHIP_ENABLE_PIN, RECEIVE_ENABLE_PIN, TRANSMIT_ENABLE_PIN} = i[2:0];
            wr(5'h10, {8'h07, i[3], i[4]});
            check("chip", CHIP_ON, i[4] & i[2]);
            check("cal", {CAL_MODE, CAL_RX, CAL_TX}, {i[3], i[3] & i[1], i[3] & i[0]});
        end
        wr(5'h0e, `RUCB_RST_HP3);
        wr(5'h0f, 10'h001);
        wr(5'h16, 10'h09c);
        wr(5'h11, 10'h155);
        check("vas", VAS_BUSY, 1'b1);
        {CLK_EN, GAIN_BIT7, GAIN_BIT6} = 3'b011;
        repeat (2) @(posedge REF_CLK);
        #1 check("freeze", HP_CORNER, 3'd0);
        CLK_EN = 1;
        repeat (4) @(posedge REF_CLK);
        #1 check("hold", HP_CORNER, 3'd1);
        repeat (1200) @(posedge REF_CLK);
        #1 check("final", HP_CORNER, 3'd0);
        check("ctrl", CORNER_CTRL_A, 1'b1);
        check("vas", VAS_BUSY, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            wr(5'h0f, {3'h4, i[0], 6'h01});
            HIGHPASS_HOLD_PIN = 1;
            repeat (3) @(posedge REF_CLK);
            #1 check("m2", HP_CORNER, 3'd4);
            HIGHPASS_HOLD_PIN = 0;
            repeat (2) @(posedge REF_CLK);
            #1 check("release", HP_CORNER, {2'b0, ~i[0]});
        end
        end_sim;
    end
endmodule
`default_nettype wire
